// file: hw/rasd_arbiter.sv
`include "rasd_regs.svh"

module rasd_arbiter
   import rasd_pkg::*;
(
   input  wire logic            clk_in,
   input  wire logic            rst_n_in,
   input  wire logic            run_halt_control_in,
   input  wire logic            break_request_in,
   input  wire logic            boundary_in,
   input  wire logic            irq_enable_in,
   input  wire logic            vector_mode_in,
   input  wire logic [4:0]      main_dev_flag_in,
   input  wire logic [4:0]      panel_dev_flag_in,
   input  wire logic            instr_valid_in,
   input  wire rasd_word_t      instr_in,
   input  wire logic            panel_cmd_in,
   input  wire rasd_panel_fn_t  panel_fn_in,
   input  wire logic [14:0]     panel_target_in,
   input  wire logic            bootstrap_in,
   input  wire logic [14:0]     pc_in,
   input  wire rasd_access_t    access_in,
   input  wire rasd_word_t      disp_data_in,
   output logic                 main_space_strobe_out,
   output logic                 panel_space_strobe_out,
   output logic                 device_space_strobe_out,
   output logic                 read_out,
   output logic                 write_out,
   output logic [2:0]           field_out,
   output logic [4:0]           page_out,
   output logic [6:0]           word_out,
   output rasd_region_t         region_out,
   output logic [3:0]           crt_param_index_out,
   output rasd_disp_word_t      disp_word_out,
   output logic                 irq_grant_out,
   output logic                 break_grant_out,
   output logic                 instruction_fetch_out,
   output rasd_op_t             op_out,
   output logic                 running_out,
   output logic                 panel_mode_out,
   output logic [14:0]          jump_addr_out,
   output logic [14:0]          saved_pc_out,
   output logic                 acc_load_out,
   output rasd_word_t           acc_value_out,
   output rasd_cause_t          entry_cause_out,
   output rasd_panel_fn_t       panel_fn_out
);

   // Device code tables of both controllers
   rasd_devcode_t main_codes  [`RASD_DEV_CNT];
   rasd_devcode_t panel_codes [`RASD_DEV_CNT];
   assign main_codes[0]  = `RASD_MAIN_DEV0;
   assign main_codes[1]  = `RASD_MAIN_DEV1;
   assign main_codes[2]  = `RASD_MAIN_DEV2;
   assign main_codes[3]  = `RASD_MAIN_DEV3;
   assign main_codes[4]  = `RASD_MAIN_DEV4;
   assign panel_codes[0] = `RASD_PANEL_DEV0;
   assign panel_codes[1] = `RASD_PANEL_DEV1;
   assign panel_codes[2] = `RASD_PANEL_DEV2;
   assign panel_codes[3] = `RASD_PANEL_DEV3;
   assign panel_codes[4] = `RASD_PANEL_DEV4;

   // Fixed-priority pick per controller, lowest index wins
   logic [4:0]    main_above;
   logic [4:0]    panel_above;
   rasd_devcode_t main_sel  [`RASD_DEV_CNT + 1];
   rasd_devcode_t panel_sel [`RASD_DEV_CNT + 1];
   assign main_sel[`RASD_DEV_CNT]  = '0;
   assign panel_sel[`RASD_DEV_CNT] = '0;

   genvar gi;
   generate
      for (gi = 0; gi < `RASD_DEV_CNT; gi++) begin : g_dev
         if (gi == 0) begin : g_first
            assign main_above[gi]  = 1'b0;
            assign panel_above[gi] = 1'b0;
         end else begin : g_rest
            assign main_above[gi]  = main_above[gi-1] |
                                     main_dev_flag_in[gi-1];
            assign panel_above[gi] = panel_above[gi-1] |
                                     panel_dev_flag_in[gi-1];
         end
         assign main_sel[gi] = main_dev_flag_in[gi] ?
                               main_codes[gi] : main_sel[gi+1];
         assign panel_sel[gi] = panel_dev_flag_in[gi] ?
                                panel_codes[gi] : panel_sel[gi+1];
      end
   endgenerate

   wire rasd_devcode_t main_code  = main_sel[0];
   wire rasd_devcode_t panel_code = panel_sel[0];
   wire main_dev_any  = |main_dev_flag_in;
   wire panel_dev_any = |panel_dev_flag_in;

   // Panel entry causes, sticky until served
   logic           power_on_q;
   logic           halt_pend_q;
   logic           cmd_pend_q;
   logic           boot_pend_q;
   rasd_panel_fn_t cmd_fn_q;
   logic [14:0]    cmd_target_q;
   logic           running_q;

   wire halt_seen = instr_valid_in &&
                    instr_in == `RASD_HALT_OPCODE;

   wire entry_any = power_on_q | halt_pend_q | cmd_pend_q | boot_pend_q;
   wire panel_req = entry_any | panel_dev_any;
   wire normal_req = main_dev_any & irq_enable_in;

   // Decision taken only at an instruction boundary
   wire take_runhalt = boundary_in & run_halt_control_in;
   wire take_break   = boundary_in & ~run_halt_control_in &
                       running_q & break_request_in;
   wire take_panel   = boundary_in & ~run_halt_control_in &
                       running_q & ~break_request_in &
                       panel_req;
   wire take_normal  = boundary_in & ~run_halt_control_in &
                       running_q & ~break_request_in &
                       ~panel_req & normal_req;
   wire take_fetch   = boundary_in & ~run_halt_control_in &
                       running_q & ~break_request_in &
                       ~panel_req & ~normal_req;

   // Which entry cause a panel grant serves
   wire rasd_cause_t cause_sel =
      power_on_q  ? RASD_CAUSE_POWER_ON :
      halt_pend_q ? RASD_CAUSE_HALT :
      cmd_pend_q  ? RASD_CAUSE_COMMAND :
      boot_pend_q ? RASD_CAUSE_BOOT : RASD_CAUSE_DEVICE;

   wire serve_pwr  = take_panel & (cause_sel == RASD_CAUSE_POWER_ON);
   wire serve_halt = take_panel & (cause_sel == RASD_CAUSE_HALT);
   wire serve_cmd  = take_panel & (cause_sel == RASD_CAUSE_COMMAND);
   wire serve_boot = take_panel & (cause_sel == RASD_CAUSE_BOOT);

   // Set wins over clear on the halt, command and boot pending causes; power-on only clears
   wire power_on_d  = power_on_q & ~serve_pwr;
   wire halt_pend_d = halt_seen | (halt_pend_q & ~serve_halt);
   wire cmd_pend_d  = panel_cmd_in | (cmd_pend_q & ~serve_cmd);
   wire boot_pend_d = bootstrap_in | (boot_pend_q & ~serve_boot);

   // Panel jump target; a jump command goes straight to its location
   wire [14:0] panel_entry = {`RASD_FIELD_MAIN0, `RASD_PANEL_ENTRY};
   wire [14:0] panel_jump  =
      (serve_cmd && cmd_fn_q == RASD_PANEL_FN_JUMP) ?
      cmd_target_q : panel_entry;
   wire [14:0] normal_jump = {`RASD_FIELD_MAIN0, `RASD_IRQ_VECTOR};

   // Return address is the next word, wrapping within the field
   wire rasd_word_t pc_next = pc_in[11:0] + `RASD_WORD_ONE;
   wire [14:0] return_pc = {pc_in[14:12], pc_next};

   // Vector code shown in the accumulator on an interrupt grant
   wire rasd_devcode_t vec_code =
      take_panel ? ((cause_sel == RASD_CAUSE_DEVICE) ? panel_code : '0)
                 : main_code;
   wire rasd_word_t acc_vec = {6'h00, vec_code};

   wire rasd_op_t op_d =
      take_runhalt ? RASD_OP_RUNHALT :
      take_break   ? RASD_OP_BREAK :
      take_panel   ? RASD_OP_PANEL :
      take_normal  ? RASD_OP_NORMAL :
      take_fetch   ? RASD_OP_FETCH : RASD_OP_NONE;

   // Both interrupt kinds share one grant
   wire irq_take = take_panel | take_normal;

   // Access decode: one space strobe per transfer
   wire acc_main  = access_in.valid & (access_in.space == RASD_SP_MAIN);
   wire acc_panel = access_in.valid & (access_in.space == RASD_SP_PANEL);
   wire acc_dev   = access_in.valid & (access_in.space == RASD_SP_DEVICE);
   wire acc_any   = acc_main | acc_panel | acc_dev;

   wire [2:0]       a_field = access_in.field;
   wire rasd_word_t a_addr  = access_in.addr;

   // Panel space field map
   wire rasd_region_t f0_region =
      (a_addr < `RASD_SCRATCH_END) ? RASD_REG_SCRATCH :
      (a_addr < `RASD_FWROM_END)   ? RASD_REG_FW_ROM :
                                     RASD_REG_UNMAPPED;
   wire rasd_region_t panel_region =
      (a_field == `RASD_FIELD_MAIN0) ? f0_region :
      (a_field == `RASD_FIELD_LANG)  ? RASD_REG_LANG_ROM :
      (a_field == `RASD_FIELD_BOOT)  ? RASD_REG_BOOT_ROM :
      (a_field == `RASD_FIELD_DISP && a_addr < `RASD_DISPLAY_END) ?
         RASD_REG_DISPLAY :
      (a_field == `RASD_FIELD_CRT && a_addr < `RASD_CRTPAR_END) ?
         RASD_REG_CRT_PARAM : RASD_REG_UNMAPPED;
   wire rasd_region_t region_d =
      acc_main  ? RASD_REG_MAIN :
      acc_panel ? panel_region : RASD_REG_UNMAPPED;

   wire [3:0] crt_idx = (panel_region == RASD_REG_CRT_PARAM) ?
                        a_addr[3:0] : 4'h0;

   // Display word layout: attributes above the character code
   wire rasd_disp_word_t disp_d = rasd_disp_word_t'(disp_data_in);

   // Control and pending state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_on_q   <= 1'b1;
         halt_pend_q  <= 1'b0;
         cmd_pend_q   <= 1'b0;
         boot_pend_q  <= 1'b0;
         cmd_fn_q     <= RASD_PANEL_FN_READ_DISPLAY;
         cmd_target_q <= '0;
         running_q    <= 1'b1;
      end else begin
         power_on_q  <= power_on_d;
         halt_pend_q <= halt_pend_d;
         cmd_pend_q  <= cmd_pend_d;
         boot_pend_q <= boot_pend_d;
         if (panel_cmd_in) begin
            cmd_fn_q     <= panel_fn_in;
            cmd_target_q <= panel_target_in;
         end
         if (take_runhalt) begin
            running_q <= ~running_q;
         end
      end
   end

   // Grant and jump outputs, registered at the boundary decision
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_grant_out         <= 1'b0;
         break_grant_out       <= 1'b0;
         instruction_fetch_out <= 1'b0;
         op_out                <= RASD_OP_NONE;
         running_out           <= 1'b1;
         panel_mode_out        <= 1'b0;
         jump_addr_out         <= '0;
         saved_pc_out          <= '0;
         acc_load_out          <= 1'b0;
         acc_value_out         <= '0;
         entry_cause_out       <= RASD_CAUSE_NONE;
         panel_fn_out          <= RASD_PANEL_FN_READ_DISPLAY;
      end else begin
         irq_grant_out         <= irq_take;
         break_grant_out       <= take_break;
         instruction_fetch_out <= take_fetch;
         op_out                <= op_d;
         running_out           <= take_runhalt ? ~running_q : running_q;
         acc_load_out  <= irq_take & vector_mode_in;
         acc_value_out <= vector_mode_in ? acc_vec : '0;
         if (take_panel) begin
            panel_mode_out  <= 1'b1;
            jump_addr_out   <= panel_jump;
            saved_pc_out    <= pc_in;
            entry_cause_out <= cause_sel;
            panel_fn_out    <= cmd_fn_q;
         end else if (take_normal) begin
            panel_mode_out  <= 1'b0;
            jump_addr_out   <= normal_jump;
            saved_pc_out    <= return_pc;
            entry_cause_out <= RASD_CAUSE_NONE;
         end
      end
   end

   // Transfer strobes and address split
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_space_strobe_out   <= 1'b0;
         panel_space_strobe_out  <= 1'b0;
         device_space_strobe_out <= 1'b0;
         read_out                <= 1'b0;
         write_out               <= 1'b0;
         field_out               <= '0;
         page_out                <= '0;
         word_out                <= '0;
         region_out              <= RASD_REG_UNMAPPED;
         crt_param_index_out     <= '0;
         disp_word_out           <= '0;
      end else begin
         main_space_strobe_out   <= acc_main;
         panel_space_strobe_out  <= acc_panel;
         device_space_strobe_out <= acc_dev;
         read_out                <= acc_any & ~access_in.write;
         write_out               <= acc_any & access_in.write;
         field_out               <= a_field;
         page_out                <= a_addr[11:7];
         word_out                <= a_addr[6:0];
         region_out              <= region_d;
         crt_param_index_out     <= crt_idx;
         disp_word_out           <= disp_d;
      end
   end

endmodule

// file: hw/rasd_regs.svh
`ifndef RASD_REGS_SVH
`define RASD_REGS_SVH
`define RASD_DEV_CNT      5
`define RASD_MAIN_DEV0    6'h03
`define RASD_MAIN_DEV1    6'h04
`define RASD_MAIN_DEV2    6'h1A
`define RASD_MAIN_DEV3    6'h1B
`define RASD_MAIN_DEV4    6'h0B
`define RASD_PANEL_DEV0   6'h09
`define RASD_PANEL_DEV1   6'h05
`define RASD_PANEL_DEV2   6'h06
`define RASD_PANEL_DEV3   6'h07
`define RASD_PANEL_DEV4   6'h0A
`define RASD_HALT_OPCODE  12'hF02
`define RASD_IRQ_VECTOR   12'h000
`define RASD_PANEL_ENTRY  12'h000
`define RASD_SCRATCH_END  12'h100
`define RASD_FWROM_END    12'hD00
`define RASD_DISPLAY_END  12'h800
`define RASD_CRTPAR_END   12'h009
`define RASD_FIELD_MAIN0  3'h0
`define RASD_FIELD_LANG   3'h1
`define RASD_FIELD_BOOT   3'h5
`define RASD_FIELD_DISP   3'h6
`define RASD_FIELD_CRT    3'h7
`define RASD_WORD_ONE     12'h001
`endif

// file: hw/rasd_pkg.sv
package rasd_pkg;
   typedef logic [11:0] rasd_word_t;
   typedef logic [5:0]  rasd_devcode_t;
   typedef enum logic [1:0] {
      RASD_SP_MAIN, RASD_SP_PANEL, RASD_SP_DEVICE, RASD_SP_NONE
   } rasd_space_t;
   typedef enum logic [2:0] {
      RASD_OP_NONE, RASD_OP_FETCH, RASD_OP_BREAK, RASD_OP_PANEL,
      RASD_OP_NORMAL, RASD_OP_RUNHALT
   } rasd_op_t;
   typedef enum logic [2:0] {
      RASD_CAUSE_NONE, RASD_CAUSE_POWER_ON, RASD_CAUSE_HALT,
      RASD_CAUSE_COMMAND, RASD_CAUSE_BOOT, RASD_CAUSE_DEVICE
   } rasd_cause_t;
   typedef enum logic [1:0] {
      RASD_PANEL_FN_READ_DISPLAY, RASD_PANEL_FN_BLOCK_WRITE,
      RASD_PANEL_FN_SETUP_ENTRY, RASD_PANEL_FN_JUMP
   } rasd_panel_fn_t;
   typedef enum logic [2:0] {
      RASD_REG_MAIN, RASD_REG_SCRATCH, RASD_REG_FW_ROM, RASD_REG_LANG_ROM,
      RASD_REG_BOOT_ROM, RASD_REG_DISPLAY, RASD_REG_CRT_PARAM,
      RASD_REG_UNMAPPED
   } rasd_region_t;
   typedef struct packed {
      logic        valid;
      rasd_space_t space;
      logic        write;
      logic [2:0]  field;
      rasd_word_t  addr;
   } rasd_access_t;
   typedef struct packed {
      logic       bold;
      logic       blink;
      logic       underline;
      logic       reverse;
      logic [7:0] char_code;
   } rasd_disp_word_t;
endpackage

// file: test/rasd_arbiter_monitor.sv
module rasd_arbiter_monitor
   import rasd_pkg::*;
(
   input wire logic            clk_in,
   input wire logic            rst_n_in,
   input wire logic            run_halt_control_in,
   input wire logic            break_request_in,
   input wire logic            boundary_in,
   input wire logic            irq_enable_in,
   input wire logic            vector_mode_in,
   input wire logic [4:0]      main_dev_flag_in,
   input wire logic [4:0]      panel_dev_flag_in,
   input wire rasd_access_t    access_in,
   input wire rasd_word_t      disp_data_in,
   input wire logic            main_space_strobe_out,
   input wire logic            panel_space_strobe_out,
   input wire logic            device_space_strobe_out,
   input wire logic            read_out,
   input wire logic            write_out,
   input wire logic [4:0]      page_out,
   input wire logic [6:0]      word_out,
   input wire rasd_disp_word_t disp_word_out,
   input wire logic            irq_grant_out,
   input wire logic            break_grant_out,
   input wire logic            instruction_fetch_out,
   input wire logic            running_out,
   input wire logic            acc_load_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_main_strobe: assert property (
      access_in.valid && access_in.space == RASD_SP_MAIN |=>
      main_space_strobe_out && !panel_space_strobe_out &&
      !device_space_strobe_out)
      else $error("main access gave wrong strobes");
   chk_read_write: assert property (
      access_in.valid && access_in.space != RASD_SP_NONE |=> write_out ==
      $past(access_in.write) && read_out != $past(access_in.write))
      else $error("read or write qualifier wrong");
   chk_grant_boundary: assert property (
      (irq_grant_out || break_grant_out || instruction_fetch_out) |->
      $past(boundary_in))
      else $error("decision without boundary");
   chk_grant_onehot: assert property (
      $onehot0({irq_grant_out, break_grant_out, instruction_fetch_out}))
      else $error("more than one decision at once");
   chk_break_first: assert property (
      boundary_in && break_request_in && running_out &&
      !run_halt_control_in |=> break_grant_out)
      else $error("break request not granted first");
   chk_fetch_idle: assert property (
      instruction_fetch_out |->
      $past(!break_request_in && panel_dev_flag_in == 5'h00 &&
      !(irq_enable_in && main_dev_flag_in != 5'h00)))
      else $error("fetch while a request was pending");
   chk_page_word: assert property (
      access_in.valid |=>
      page_out == $past(access_in.addr[11:7]) &&
      word_out == $past(access_in.addr[6:0]))
      else $error("page or word split wrong");
   chk_disp_word: assert property (
      1'b1 |=> disp_word_out == $past(disp_data_in))
      else $error("display word decode wrong");
   chk_acc_vector: assert property (
      acc_load_out |-> irq_grant_out && $past(vector_mode_in))
      else $error("accumulator load without vectored grant");
   chk_halted_quiet: assert property (
      boundary_in && !running_out && !run_halt_control_in |=>
      !irq_grant_out && !break_grant_out && !instruction_fetch_out)
      else $error("activity while halted");
endmodule

bind rasd_arbiter rasd_arbiter_monitor mon (
   .clk_in, .rst_n_in, .run_halt_control_in, .break_request_in,
   .boundary_in, .irq_enable_in, .vector_mode_in, .main_dev_flag_in,
   .panel_dev_flag_in, .access_in, .disp_data_in, .main_space_strobe_out,
   .panel_space_strobe_out, .device_space_strobe_out, .read_out,
   .write_out, .page_out, .word_out, .disp_word_out, .irq_grant_out,
   .break_grant_out, .instruction_fetch_out, .running_out, .acc_load_out
);

// file: test/rasd_dev_model.sv
module rasd_dev_model
   import rasd_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [4:0]  main_set_in,
   input  wire logic [4:0]  panel_set_in,
   input  wire logic        break_set_in,
   input  wire logic        irq_grant_in,
   input  wire logic        break_grant_in,
   input  wire rasd_op_t    op_in,
   input  wire rasd_cause_t cause_in,
   output logic [4:0]       main_flag_out,
   output logic [4:0]       panel_flag_out,
   output logic             break_request_out
);
   logic [4:0] main_q, panel_q, main_clr, panel_clr;
   logic       brk_q;
   // Granted device is the highest ranked one still raised
   assign main_clr = (irq_grant_in && op_in == RASD_OP_NORMAL) ?
                     main_q & (~main_q + 5'h01) : 5'h00;
   assign panel_clr = (irq_grant_in && op_in == RASD_OP_PANEL &&
      cause_in == RASD_CAUSE_DEVICE) ? panel_q & (~panel_q + 5'h01) : 5'h00;
   assign main_flag_out = main_q;
   assign panel_flag_out = panel_q;
   assign break_request_out = brk_q;
   // Requests held until their grant is seen
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_q <= 5'h00;
         panel_q <= 5'h00;
         brk_q <= 1'b0;
      end else begin
         main_q <= (main_q & ~main_clr) | main_set_in;
         panel_q <= (panel_q & ~panel_clr) | panel_set_in;
         brk_q <= (brk_q & ~break_grant_in) | break_set_in;
      end
   end
endmodule

// file: test/test_request_arbiter_space_decode.sv
module test_request_arbiter_space_decode;
   timeunit 1ns;
   timeprecision 1ps;
   import rasd_pkg::*;
   logic clk_in, rst_n_in, run_halt_control_in, break_request_in;
   logic boundary_in, irq_enable_in, vector_mode_in, instr_valid_in;
   logic panel_cmd_in, bootstrap_in, bset, main_space_strobe_out;
   logic panel_space_strobe_out, device_space_strobe_out, read_out;
   logic write_out, irq_grant_out, break_grant_out, instruction_fetch_out;
   logic running_out, panel_mode_out, acc_load_out;
   logic [4:0] main_dev_flag_in, panel_dev_flag_in, mset, pset, page_out;
   logic [14:0] panel_target_in, pc_in, jump_addr_out, saved_pc_out;
   logic [2:0] field_out;
   logic [6:0] word_out;
   logic [3:0] crt_param_index_out;
   rasd_word_t instr_in, disp_data_in, acc_value_out;
   rasd_panel_fn_t panel_fn_in, panel_fn_out;
   rasd_access_t access_in;
   rasd_region_t region_out;
   rasd_disp_word_t disp_word_out;
   rasd_op_t op_out;
   rasd_cause_t entry_cause_out;
   int mismatches, n_checks, cyc;
   logic [5:0] codes[10] = '{6'h09, 6'h05, 6'h06, 6'h07, 6'h0A,
                            6'h03, 6'h04, 6'h1A, 6'h1B, 6'h0B};
   logic [14:0] ad[11] = '{15'h00FF, 15'h0100, 15'h0CFF, 15'h0D00,
      15'h1123, 15'h3000, 15'h5456, 15'h67FF, 15'h6800, 15'h7008, 15'h7009};
   rasd_region_t rg[11] = '{RASD_REG_SCRATCH, RASD_REG_FW_ROM,
      RASD_REG_FW_ROM, RASD_REG_UNMAPPED, RASD_REG_LANG_ROM,
      RASD_REG_UNMAPPED, RASD_REG_BOOT_ROM, RASD_REG_DISPLAY,
      RASD_REG_UNMAPPED, RASD_REG_CRT_PARAM, RASD_REG_UNMAPPED};
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   rasd_arbiter dut (.clk_in, .rst_n_in, .run_halt_control_in,
      .break_request_in, .boundary_in, .irq_enable_in, .vector_mode_in,
      .main_dev_flag_in, .panel_dev_flag_in, .instr_valid_in, .instr_in,
      .panel_cmd_in, .panel_fn_in, .panel_target_in, .bootstrap_in, .pc_in,
      .access_in, .disp_data_in, .main_space_strobe_out,
      .panel_space_strobe_out, .device_space_strobe_out, .read_out,
      .write_out, .field_out, .page_out, .word_out, .region_out,
      .crt_param_index_out, .disp_word_out, .irq_grant_out, .break_grant_out,
      .instruction_fetch_out, .op_out, .running_out, .panel_mode_out,
      .jump_addr_out, .saved_pc_out, .acc_load_out, .acc_value_out,
      .entry_cause_out, .panel_fn_out);
   rasd_dev_model model (.clk_in, .rst_n_in, .main_set_in(mset),
      .panel_set_in(pset), .break_set_in(bset), .irq_grant_in(irq_grant_out),
      .break_grant_in(break_grant_out), .op_in(op_out),
      .cause_in(entry_cause_out), .main_flag_out(main_dev_flag_in),
      .panel_flag_out(panel_dev_flag_in), .break_request_out(break_request_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bnd(input logic rh);
      @(posedge clk_in);
      boundary_in <= 1'b1;
      run_halt_control_in <= rh;
      @(posedge clk_in);
      boundary_in <= 1'b0;
      run_halt_control_in <= 1'b0;
      @(negedge clk_in);
   endtask
   task automatic grant(input rasd_op_t op, input logic [11:0] acc);
      chk(irq_grant_out, op == RASD_OP_PANEL || op == RASD_OP_NORMAL);
      chk(break_grant_out, op == RASD_OP_BREAK);
      chk(instruction_fetch_out, op == RASD_OP_FETCH);
      chk(op_out, op);
      chk(acc_value_out, acc);
   endtask
   task automatic pulse(input logic [4:0] m, input logic [4:0] p,
                        input logic b);
      @(posedge clk_in);
      mset <= m;
      pset <= p;
      bset <= b;
      @(posedge clk_in);
      mset <= 5'h00;
      pset <= 5'h00;
      bset <= 1'b0;
   endtask
   task automatic t_power_on;
      bnd(1'b0);
      grant(RASD_OP_PANEL, 12'h000);
      chk(entry_cause_out, RASD_CAUSE_POWER_ON);
      chk(panel_mode_out, 1'b1);
      chk(jump_addr_out, 15'h0000);
      chk(saved_pc_out, 15'h3456);
      bnd(1'b0);
      grant(RASD_OP_FETCH, 12'h000);
   endtask
   task automatic t_chain;
      @(posedge clk_in);
      irq_enable_in <= 1'b1;
      vector_mode_in <= 1'b1;
      pulse(5'h1F, 5'h1F, 1'b0);
      for (int i = 0; i < 10; i++) begin
         bnd(1'b0);
         grant(i < 5 ? RASD_OP_PANEL : RASD_OP_NORMAL,
               {6'h00, codes[i]});
         chk(acc_load_out, 1'b1);
      end
      chk(panel_mode_out, 1'b0);
      chk(jump_addr_out, 15'h0000);
      chk(saved_pc_out, 15'h3457);
   endtask
   task automatic t_refuse;
      @(posedge clk_in);
      irq_enable_in <= 1'b0;
      vector_mode_in <= 1'b0;
      pulse(5'h04, 5'h00, 1'b1);
      bnd(1'b0);
      grant(RASD_OP_BREAK, 12'h000);
      bnd(1'b0);
      grant(RASD_OP_FETCH, 12'h000);
      @(posedge clk_in);
      irq_enable_in <= 1'b1;
      bnd(1'b0);
      grant(RASD_OP_NORMAL, 12'h000);
      chk(acc_load_out, 1'b0);
   endtask
   task automatic t_entry;
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      instr_in <= 12'hF02;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      bnd(1'b0);
      chk(entry_cause_out, RASD_CAUSE_HALT);
      for (int f = 0; f < 4; f++) begin
         @(posedge clk_in);
         panel_cmd_in <= 1'b1;
         panel_fn_in <= rasd_panel_fn_t'(f);
         @(posedge clk_in);
         panel_cmd_in <= 1'b0;
         bnd(1'b0);
         chk(entry_cause_out, RASD_CAUSE_COMMAND);
         chk(panel_fn_out, f);
         chk(jump_addr_out, f == 3 ? 15'h5123 : 15'h0000);
      end
      @(posedge clk_in);
      bootstrap_in <= 1'b1;
      @(posedge clk_in);
      bootstrap_in <= 1'b0;
      bnd(1'b0);
      chk(entry_cause_out, RASD_CAUSE_BOOT);
   endtask
   task automatic t_runhalt;
      bnd(1'b1);
      chk(running_out, 1'b0);
      pulse(5'h00, 5'h00, 1'b1);
      bnd(1'b0);
      grant(RASD_OP_NONE, 12'h000);
      bnd(1'b1);
      chk(running_out, 1'b1);
      bnd(1'b0);
      chk(break_grant_out, 1'b1);
   endtask
   task automatic acc(input rasd_space_t sp, input logic wr,
                      input logic [14:0] a);
      @(posedge clk_in);
      access_in <= '{1'b1, sp, wr, a[14:12], a[11:0]};
      disp_data_in <= a[11:0];
      @(posedge clk_in);
      access_in.valid <= 1'b0;
      @(negedge clk_in);
      chk(disp_word_out, a[11:0]);
   endtask
   task automatic t_access;
      for (int s = 0; s < 8; s++) begin
         acc(rasd_space_t'(s / 2), s[0], 15'h2ABC);
         chk(main_space_strobe_out, s / 2 == 0);
         chk(panel_space_strobe_out, s / 2 == 1);
         chk(device_space_strobe_out, s / 2 == 2);
         chk({read_out, write_out}, s / 2 == 3 ? 0 : s[0] ? 1 : 2);
         chk({field_out, page_out, word_out}, 15'h2ABC);
         chk(region_out, s / 2 == 0 ? 0 : 7);
      end
      for (int i = 0; i < 11; i++) begin
         acc(RASD_SP_PANEL, 1'b0, ad[i]);
         chk(region_out, rg[i]);
         chk(crt_param_index_out, i == 9 ? 4'h8 : 4'h0);
      end
   endtask
   task automatic t_reset_mid;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      @(negedge clk_in);
      chk(running_out, 1'b1);
      chk({op_out, panel_mode_out, saved_pc_out}, 0);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      bnd(1'b0);
      chk(entry_cause_out, RASD_CAUSE_POWER_ON);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      {rst_n_in, run_halt_control_in, boundary_in, irq_enable_in} = 4'h0;
      {vector_mode_in, instr_valid_in, panel_cmd_in, bootstrap_in} = 4'h0;
      {mset, pset, bset, instr_in, disp_data_in, access_in} = '0;
      panel_fn_in = RASD_PANEL_FN_READ_DISPLAY;
      panel_target_in = 15'h5123;
      pc_in = 15'h3456;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      chk(running_out, 1'b1);
      chk(region_out, RASD_REG_UNMAPPED);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_power_on();
      t_chain();
      t_refuse();
      t_entry();
      t_runhalt();
      t_access();
      t_reset_mid();
      print_verdict();
   end
endmodule
